// ### hw/rvs_defs.vh
// Register offsets, field positions, reset values and preset constants for the reference validation block
`ifndef RVS_DEFS_VH
`define RVS_DEFS_VH
// Register indices as printed; byte address is four times the index
`define RVS_IDX_REF_IRQ_CLEAR      12'hA08
`define RVS_IDX_SPARE_IRQ_CLEAR    12'hA09
`define RVS_IDX_PHASE_STEP_CTRL    12'hA0A
`define RVS_IDX_FORCE_TIMEOUT      12'hA0B
`define RVS_IDX_MON_OVERRIDE       12'hA0C
`define RVS_IDX_MON_BYPASS         12'hA0D
`define RVS_IDX_STEP_SIZE_LO       12'h312
`define RVS_IDX_STEP_SIZE_HI       12'h313
`define RVS_IDX_SEC1_ENABLE        12'hC00
`define RVS_IDX_FREQ_SELECT        12'hC01
`define RVS_IDX_SYS_PLL_SELECT     12'hC02
`define RVS_IDX_SEC2_ENABLE        12'hC03
`define RVS_IDX_REF_SCALE          12'hC04
`define RVS_IDX_OUT_SCALE          12'hC05
`define RVS_IDX_SOFT_START         12'hC07
`define RVS_IDX_IRQ_FLAGS          12'hC10
`define RVS_IDX_PHASE_OFFSET       12'hC11
`define RVS_IDX_REF_STATUS         12'hC12
// Field positions
`define RVS_BIT_REF1_VALIDATED     6
`define RVS_BIT_REF1_FAULT_CLR     5
`define RVS_BIT_REF1_FAULT         4
`define RVS_BIT_REF0_VALIDATED     2
`define RVS_BIT_REF0_FAULT_CLR     1
`define RVS_BIT_REF0_FAULT         0
`define RVS_BIT_PHASE_ZERO         2
`define RVS_BIT_PHASE_DEC          1
`define RVS_BIT_PHASE_INC          0
`define RVS_BIT_ENABLE             0
`define RVS_BIT_START              0
// Field masks of writable bits
`define RVS_MASK_IRQ               8'h77
`define RVS_MASK_TWO               8'h03
`define RVS_MASK_ONE               8'h01
`define RVS_MASK_SCALE             8'h0F
// Reset values
`define RVS_RST_BYTE               8'h00
`define RVS_RST_STEP               16'h0000
`define RVS_RST_OFFSET             32'h0000_0000
// Scale shift per code: divide by 1, 4, 8, 16
`define RVS_SHIFT_00               5'h00
`define RVS_SHIFT_01               5'h02
`define RVS_SHIFT_10               5'h03
`define RVS_SHIFT_11               5'h04
// System PLL presets: input MHz in kHz, doubler, feedback divide
`define RVS_PLL0_KHZ               16'h6000
`define RVS_PLL1_KHZ               16'hC000
`define RVS_PLL0_N                 6'h10
`define RVS_PLL1_N                 6'h08
`define RVS_PLL2_N                 6'h20
`define RVS_PLL3_N                 6'h10
// ROM download length in cycles
`define RVS_DOWNLOAD_CYCLES        8'h40
`endif

// ### hw/rvs_regs.v
// APB register bank for reference validation, phase offset stepping and soft pin presets
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "rvs_defs.vh"

module rvs_regs #(
   parameter TIMER_CYCLES = 8'h80
) (
   // APB
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [15:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Reference monitors and strap
   input  wire        strap_select_pin,
   input  wire [1:0]  ref_fault,
   // Reference validity and phase offset
   output reg  [1:0]  ref_valid,
   output reg  [1:0]  ref_irq,
   output reg  [31:0] phase_offset,
   // Preset configuration
   output reg         rom_load,
   output reg  [7:0]  rom_translation,
   output reg  [1:0]  rom_sys_pll,
   output reg  [5:0]  sys_pll_n,
   output reg         sys_pll_doubler,
   output reg         sys_pll_crystal,
   output reg  [4:0]  ref0_shift,
   output reg  [4:0]  ref1_shift,
   output reg  [4:0]  ch0_shift,
   output reg  [4:0]  ch1_shift
);

   localparam ST_IDLE = 2'b01;
   localparam ST_LOAD = 2'b10;

   function [4:0] rvs_shift;
      input [1:0] code;
      begin
         case (code)
            2'b00:   rvs_shift = `RVS_SHIFT_00;
            2'b01:   rvs_shift = `RVS_SHIFT_01;
            2'b10:   rvs_shift = `RVS_SHIFT_10;
            default: rvs_shift = `RVS_SHIFT_11;
         endcase
      end
   endfunction

   reg  [7:0]  mon_override;
   reg  [7:0]  mon_bypass;
   reg  [15:0] step_size;
   reg  [7:0]  sec1_enable;
   reg  [7:0]  freq_select;
   reg  [7:0]  sys_pll_select;
   reg  [7:0]  sec2_enable;
   reg  [7:0]  ref_scale;
   reg  [7:0]  out_scale;
   reg         strap_latched;
   reg         strap_seen;
   reg  [5:0]  irq_flags;
   reg  [1:0]  state;
   reg  [7:0]  load_count;
   reg  [7:0]  val_timer [0:1];
   reg  [1:0]  timer_run;

   wire [11:0] idx      = paddr[13:2];
   wire        word_ok  = (paddr[1:0] == 2'b00) && (paddr[15:14] == 2'b00);
   wire        wr       = psel && penable && pwrite && word_ok;
   wire [7:0]  wb       = pwdata[7:0];
   wire        sec1_on  = sec1_enable[`RVS_BIT_ENABLE] && !strap_latched;
   wire        sec2_on  = sec2_enable[`RVS_BIT_ENABLE] && !strap_latched;

   function rvs_hit;
      input [11:0] want;
      begin
         rvs_hit = wr && (idx == want);
      end
   endfunction

   wire w_irq   = rvs_hit(`RVS_IDX_REF_IRQ_CLEAR);
   wire w_phase = rvs_hit(`RVS_IDX_PHASE_STEP_CTRL);
   wire w_force = rvs_hit(`RVS_IDX_FORCE_TIMEOUT);
   wire w_start = rvs_hit(`RVS_IDX_SOFT_START);

   reg  [7:0] rd_byte;
   reg        rd_ok;

   always @* begin
      rd_ok   = 1'b1;
      rd_byte = `RVS_RST_BYTE;
      case (idx)
         `RVS_IDX_REF_IRQ_CLEAR,
         `RVS_IDX_SPARE_IRQ_CLEAR,
         `RVS_IDX_PHASE_STEP_CTRL,
         `RVS_IDX_FORCE_TIMEOUT:  rd_byte = `RVS_RST_BYTE;
         `RVS_IDX_MON_OVERRIDE:   rd_byte = mon_override;
         `RVS_IDX_MON_BYPASS:     rd_byte = mon_bypass;
         `RVS_IDX_STEP_SIZE_LO:   rd_byte = step_size[7:0];
         `RVS_IDX_STEP_SIZE_HI:   rd_byte = step_size[15:8];
         `RVS_IDX_SEC1_ENABLE:    rd_byte = sec1_enable;
         `RVS_IDX_FREQ_SELECT:    rd_byte = freq_select;
         `RVS_IDX_SYS_PLL_SELECT: rd_byte = sys_pll_select;
         `RVS_IDX_SEC2_ENABLE:    rd_byte = sec2_enable;
         `RVS_IDX_REF_SCALE:      rd_byte = ref_scale;
         `RVS_IDX_OUT_SCALE:      rd_byte = out_scale;
         `RVS_IDX_SOFT_START:     rd_byte = {7'h00, state[1]};
         `RVS_IDX_IRQ_FLAGS:      rd_byte = {1'b0, irq_flags[5:3], 1'b0, irq_flags[2:0]};
         `RVS_IDX_REF_STATUS:     rd_byte = {3'h0, strap_latched, timer_run, ref_valid};
         `RVS_IDX_PHASE_OFFSET:   rd_byte = `RVS_RST_BYTE;
         default:                 rd_ok   = 1'b0;
      endcase
   end

   // APB slave: zero wait states, answers in the access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= `RVS_RST_OFFSET;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !(word_ok && rd_ok);
         if (psel && !penable && !pwrite) begin
            if (idx == `RVS_IDX_PHASE_OFFSET)
               prdata <= phase_offset;
            else
               prdata <= {24'h000000, rd_byte};
         end
      end
   end

   // Strap caught at the first clock after reset release
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_latched <= 1'b0;
         strap_seen    <= 1'b0;
      end else if (!strap_seen) begin
         strap_latched <= strap_select_pin;
         strap_seen    <= 1'b1;
      end
   end

   // Stored registers; reserved bits masked off
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mon_override   <= `RVS_RST_BYTE;
         mon_bypass     <= `RVS_RST_BYTE;
         step_size      <= `RVS_RST_STEP;
         sec1_enable    <= `RVS_RST_BYTE;
         freq_select    <= `RVS_RST_BYTE;
         sys_pll_select <= `RVS_RST_BYTE;
         sec2_enable    <= `RVS_RST_BYTE;
         ref_scale      <= `RVS_RST_BYTE;
         out_scale      <= `RVS_RST_BYTE;
      end else begin
         if (rvs_hit(`RVS_IDX_MON_OVERRIDE))   mon_override   <= wb & `RVS_MASK_TWO;
         if (rvs_hit(`RVS_IDX_MON_BYPASS))     mon_bypass     <= wb & `RVS_MASK_TWO;
         if (rvs_hit(`RVS_IDX_STEP_SIZE_LO))   step_size[7:0] <= wb;
         if (rvs_hit(`RVS_IDX_STEP_SIZE_HI))   step_size[15:8] <= wb;
         if (rvs_hit(`RVS_IDX_SEC1_ENABLE))    sec1_enable    <= wb & `RVS_MASK_ONE;
         if (rvs_hit(`RVS_IDX_FREQ_SELECT))    freq_select    <= wb;
         if (rvs_hit(`RVS_IDX_SYS_PLL_SELECT)) sys_pll_select <= wb & `RVS_MASK_TWO;
         if (rvs_hit(`RVS_IDX_SEC2_ENABLE))    sec2_enable    <= wb & `RVS_MASK_ONE;
         if (rvs_hit(`RVS_IDX_REF_SCALE))      ref_scale      <= wb & `RVS_MASK_SCALE;
         if (rvs_hit(`RVS_IDX_OUT_SCALE))      out_scale      <= wb & `RVS_MASK_SCALE;
      end
   end

   // Phase offset: zero wins over decrement, decrement over increment
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         phase_offset <= `RVS_RST_OFFSET;
      else if (w_phase && wb[`RVS_BIT_PHASE_ZERO])
         phase_offset <= `RVS_RST_OFFSET;
      else if (w_phase && wb[`RVS_BIT_PHASE_DEC])
         phase_offset <= phase_offset - {16'h0000, step_size};
      else if (w_phase && wb[`RVS_BIT_PHASE_INC])
         phase_offset <= phase_offset + {16'h0000, step_size};
   end

   // Validation per reference; fault events raise sticky flags
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gen_ref
         wire bad      = mon_override[g] || (ref_fault[g] && !mon_bypass[g]);
         wire forced   = w_force && wb[g];
         wire expired  = timer_run[g] && (val_timer[g] == TIMER_CYCLES);
         wire go_valid = !bad && !ref_valid[g] && (forced || expired);
         wire go_fault = bad && (ref_valid[g] || timer_run[g]);
         wire clr_f    = w_irq && wb[4*g];
         wire clr_fc   = w_irq && wb[4*g + 1];
         wire clr_v    = w_irq && wb[4*g + 2];
         reg  bad_q;

         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ref_valid[g]  <= 1'b0;
               timer_run[g]  <= 1'b0;
               val_timer[g]  <= 8'h00;
               bad_q         <= 1'b0; // Idle level, so no false fault-cleared event after reset
               irq_flags[3*g]     <= 1'b0;
               irq_flags[3*g + 1] <= 1'b0;
               irq_flags[3*g + 2] <= 1'b0;
            end else begin
               bad_q <= bad;
               if (bad) begin
                  ref_valid[g] <= 1'b0;
                  timer_run[g] <= 1'b0;
                  val_timer[g] <= 8'h00;
               end else if (go_valid) begin
                  ref_valid[g] <= 1'b1;
                  timer_run[g] <= 1'b0;
               end else if (!ref_valid[g] && !timer_run[g]) begin
                  timer_run[g] <= 1'b1;
                  val_timer[g] <= 8'h00;
               end else if (timer_run[g]) begin
                  val_timer[g] <= val_timer[g] + 8'h01;
               end
               // Set wins over clear
               irq_flags[3*g]     <= go_fault | (irq_flags[3*g] & ~clr_f);
               irq_flags[3*g + 1] <= (bad_q & ~bad) | (irq_flags[3*g + 1] & ~clr_fc);
               irq_flags[3*g + 2] <= go_valid | (irq_flags[3*g + 2] & ~clr_v);
            end
         end
      end
   endgenerate

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ref_irq <= 2'b00;
      else
         ref_irq <= {|irq_flags[5:3], |irq_flags[2:0]};
   end

   // ROM download sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state      <= ST_IDLE;
         load_count <= 8'h00;
         rom_load   <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               rom_load <= 1'b0;
               if (w_start && wb[`RVS_BIT_START]) begin
                  state      <= ST_LOAD;
                  load_count <= `RVS_DOWNLOAD_CYCLES;
                  rom_load   <= 1'b1;
               end
            end
            ST_LOAD: begin
               load_count <= load_count - 8'h01;
               if (load_count == 8'h01) begin
                  state    <= ST_IDLE;
                  rom_load <= 1'b0;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // With the strap latched low, section 1 presets apply while a download runs with it enabled and section 2 scaling follows its enable every cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rom_translation <= 8'h00;
         rom_sys_pll     <= 2'b00;
         sys_pll_n       <= `RVS_PLL0_N;
         sys_pll_doubler <= 1'b1;
         sys_pll_crystal <= 1'b1;
         ref0_shift      <= `RVS_SHIFT_00;
         ref1_shift      <= `RVS_SHIFT_00;
         ch0_shift       <= `RVS_SHIFT_00;
         ch1_shift       <= `RVS_SHIFT_00;
      end else begin
         if (sec1_on && state[1]) begin
            rom_translation <= freq_select;
            rom_sys_pll     <= sys_pll_select[1:0];
            sys_pll_crystal <= !sys_pll_select[1];
            sys_pll_doubler <= !sys_pll_select[1];
            case (sys_pll_select[1:0])
               2'b00:   sys_pll_n <= `RVS_PLL0_N;
               2'b01:   sys_pll_n <= `RVS_PLL1_N;
               2'b10:   sys_pll_n <= `RVS_PLL2_N;
               default: sys_pll_n <= `RVS_PLL3_N;
            endcase
         end
         if (sec2_on) begin
            ref0_shift <= rvs_shift(ref_scale[1:0]);
            ref1_shift <= rvs_shift(ref_scale[3:2]);
            ch0_shift  <= rvs_shift(out_scale[1:0]);
            ch1_shift  <= rvs_shift(out_scale[3:2]);
         end else begin
            ref0_shift <= `RVS_SHIFT_00;
            ref1_shift <= `RVS_SHIFT_00;
            ch0_shift  <= `RVS_SHIFT_00;
            ch1_shift  <= `RVS_SHIFT_00;
         end
      end
   end

endmodule // rvs_regs

// ### tb/rvs_regs_monitor.sv
// Checker for the reference validation register bank
`timescale 1ns/100ps
`include "rvs_defs.vh"
module rvs_regs_monitor #(
   parameter TIMER_CYCLES = 8'h80
) (
   // APB
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [15:0] paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire        pslverr,
   // Device side
   input wire        strap_select_pin,
   input wire [1:0]  ref_fault,
   input wire [1:0]  ref_valid,
   input wire [31:0] phase_offset,
   input wire        rom_load,
   input wire [4:0]  ref0_shift,
   input wire [4:0]  ref1_shift,
   input wire [4:0]  ch0_shift,
   input wire [4:0]  ch1_shift
);
   function automatic [15:0] ba(input [11:0] i);
      ba = {2'b00, i, 2'b00};
   endfunction
   function automatic [4:0] shf(input [1:0] c);
      shf = (c == 2'b00) ? 5'h00 : {3'h0, c} + 5'h01;
   endfunction
   wire       wr = psel && penable && pwrite && pready && !pslverr;
   wire       wp = wr && paddr == ba(`RVS_IDX_PHASE_STEP_CTRL);
   reg [15:0] step;
   reg [1:0]  ovr;
   reg [1:0]  byp;
   reg        sec2;
   reg [3:0]  rsc;
   reg [3:0]  osc;
   // Shadow copies so offsets and shifts are judged against what software wrote
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step <= 16'h0000;
         ovr  <= 2'h0;
         byp  <= 2'h0;
         sec2 <= 1'b0;
         rsc  <= 4'h0;
         osc  <= 4'h0;
      end else if (wr) begin
         case (paddr)
            ba(`RVS_IDX_STEP_SIZE_LO): step[7:0] <= pwdata[7:0];
            ba(`RVS_IDX_STEP_SIZE_HI): step[15:8] <= pwdata[7:0];
            ba(`RVS_IDX_MON_OVERRIDE): ovr <= pwdata[1:0];
            ba(`RVS_IDX_MON_BYPASS):   byp <= pwdata[1:0];
            ba(`RVS_IDX_SEC2_ENABLE):  sec2 <= pwdata[0];
            ba(`RVS_IDX_REF_SCALE):    rsc <= pwdata[3:0];
            ba(`RVS_IDX_OUT_SCALE):    osc <= pwdata[3:0];
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_zero; wp && pwdata[2] |=> phase_offset == 32'h0; endproperty
   a_zero: assert property (p_zero) else $error("phase offset not zeroed");
   property p_dec; wp && pwdata[2:1] == 2'b01 |=> phase_offset == $past(phase_offset) - {16'h0, step}; endproperty
   a_dec: assert property (p_dec) else $error("phase offset not decremented");
   property p_inc; wp && pwdata[2:0] == 3'b001 |=> phase_offset == $past(phase_offset) + {16'h0, step}; endproperty
   a_inc: assert property (p_inc) else $error("phase offset not incremented");
   property p_noop; wp && pwdata[2:0] == 3'b000 |=> $stable(phase_offset); endproperty
   a_noop: assert property (p_noop) else $error("zero write moved offset");
   property p_force;
      wr && paddr == ba(`RVS_IDX_FORCE_TIMEOUT) && pwdata[0] && !ovr[0] && (!ref_fault[0] || byp[0])
      |=> ref_valid[0];
   endproperty
   a_force: assert property (p_force) else $error("forced timeout did not validate");
   property p_ovr; (ovr & $past(ovr) & ref_valid) == 2'b00; endproperty
   a_ovr: assert property (p_ovr) else $error("overridden reference still valid");
   property p_off; !$past(sec2) |-> {ref0_shift, ref1_shift, ch0_shift, ch1_shift} == 20'h0; endproperty
   a_off: assert property (p_off) else $error("scaling active while disabled");
   property p_rsc;
      $past(sec2) && !strap_select_pin
      |-> ref0_shift == shf($past(rsc[1:0])) && ref1_shift == shf($past(rsc[3:2]));
   endproperty
   a_rsc: assert property (p_rsc) else $error("reference scale mismatch");
   property p_osc;
      $past(sec2) && !strap_select_pin
      |-> ch0_shift == shf($past(osc[1:0])) && ch1_shift == shf($past(osc[3:2]));
   endproperty
   a_osc: assert property (p_osc) else $error("output scale mismatch");
   property p_load;
      wr && paddr == ba(`RVS_IDX_SOFT_START) && pwdata[0] && !rom_load
      |=> rom_load[*8] ##56 rom_load ##1 !rom_load;
   endproperty
   a_load: assert property (p_load) else $error("download length wrong");
endmodule // rvs_regs_monitor

bind rvs_regs rvs_regs_monitor #(.TIMER_CYCLES(TIMER_CYCLES)) i_rvs_regs_monitor (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .strap_select_pin(strap_select_pin), .ref_fault(ref_fault), .ref_valid(ref_valid),
   .phase_offset(phase_offset), .rom_load(rom_load), .ref0_shift(ref0_shift),
   .ref1_shift(ref1_shift), .ch0_shift(ch0_shift), .ch1_shift(ch1_shift));

// ### tb/tb_top.sv
// Self-checking bench for the reference validation register bank
`timescale 1ns/100ps
`include "rvs_defs.vh"
module tb_top;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, strap = 0;
   logic [15:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, phase_offset, rd;
   logic [1:0]  ref_fault = 0, ref_valid, ref_irq, rom_sys_pll;
   logic        pready, pslverr, rom_load, dbl, cry, er;
   logic [7:0]  rom_translation;
   logic [5:0]  pll_n;
   logic [4:0]  sa, sb, s0, s1;
   int          n_fail = 0, n_compared = 0;
   logic [4:0]  dv [4] = '{5'h00, 5'h02, 5'h03, 5'h04}; // log2 of 1, 4, 8, 16
   logic [7:0]  pl [4] = '{8'h43, 8'h23, 8'h80, 8'h40}; // {N, doubler, crystal}
   rvs_regs #(.TIMER_CYCLES(8'h10)) i_rvs_regs (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .strap_select_pin(strap), .ref_fault(ref_fault), .ref_valid(ref_valid), .ref_irq(ref_irq),
      .phase_offset(phase_offset), .rom_load(rom_load), .rom_translation(rom_translation),
      .rom_sys_pll(rom_sys_pll), .sys_pll_n(pll_n), .sys_pll_doubler(dbl), .sys_pll_crystal(cry),
      .ref0_shift(sa), .ref1_shift(sb), .ch0_shift(s0), .ch1_shift(s1));
   always #2.5 pclk = ~pclk;
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task test_done;
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task clks(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Full APB cycle; one idle edge after release keeps drivers single-assigned
   task apb(input logic w, input logic [11:0] i, input logic [7:0] d);
      int n;
      psel <= 1;
      pwrite <= w;
      paddr <= {2'b00, i, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         test_done;
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task rst(input logic s);
      presetn <= 0;
      strap <= s;
      clks(16);
      presetn <= 1;
      @(posedge pclk);
   endtask
   initial begin
      logic [31:0] ex;
      logic [15:0] st;
      logic [7:0]  sel;
      logic [2:0]  op;
      int          k;
      void'($urandom(32'h35212B9E));
      rst(0);
      ex = 0;
      for (k = 0; k < 40; k++) begin
         st = $urandom;
         op = $urandom;
         apb(1, `RVS_IDX_STEP_SIZE_LO, st[7:0]);
         apb(1, `RVS_IDX_STEP_SIZE_HI, st[15:8]);
         apb(1, `RVS_IDX_PHASE_STEP_CTRL, {5'h0, op});
         ex = op[2] ? 32'h0 : op[1] ? ex - st : op[0] ? ex + st : ex;
         chk(phase_offset, ex);
      end
      apb(0, `RVS_IDX_PHASE_STEP_CTRL, 0);
      chk(rd, 0);
      apb(1, `RVS_IDX_SPARE_IRQ_CLEAR, 8'hFF);
      apb(0, `RVS_IDX_SPARE_IRQ_CLEAR, 0);
      chk(rd, 0);
      apb(0, 12'h100, 0);
      chk(er, 1);
      $display("phase and map test done");
      for (k = 0; k < 2; k++) begin
         ref_fault[k] <= 1;
         clks(8);
         ref_fault[k] <= 0;
         clks(40);
         apb(1, `RVS_IDX_REF_IRQ_CLEAR, 8'h00);
         chk(ref_irq[k], 1);
         apb(1, `RVS_IDX_REF_IRQ_CLEAR, k ? 8'h07 : 8'h70);
         chk(ref_irq[k], 1);
         apb(1, `RVS_IDX_REF_IRQ_CLEAR, k ? 8'h70 : 8'h07);
         clks(1);
         chk(ref_irq[k], 0);
      end
      $display("irq clear test done");
      ref_fault <= 2'b11;
      apb(1, `RVS_IDX_MON_OVERRIDE, 8'hFF);
      apb(0, `RVS_IDX_MON_OVERRIDE, 0);
      chk(rd, 8'h03);
      apb(1, `RVS_IDX_MON_OVERRIDE, 0);
      apb(1, `RVS_IDX_MON_BYPASS, 8'h03);
      apb(1, `RVS_IDX_FORCE_TIMEOUT, 8'h03);
      clks(1);
      chk(ref_valid, 2'b11);
      apb(0, `RVS_IDX_FORCE_TIMEOUT, 0);
      chk(rd, 0);
      apb(1, `RVS_IDX_MON_OVERRIDE, 8'h02);
      clks(1);
      chk(ref_valid, 2'b01);
      apb(1, `RVS_IDX_MON_OVERRIDE, 0);
      $display("validation test done");
      chk({sa, sb, s0, s1}, 0);
      for (k = 0; k < 16; k++) begin
         apb(1, `RVS_IDX_REF_SCALE, k);
         apb(1, `RVS_IDX_OUT_SCALE, 15 - k);
         apb(1, `RVS_IDX_SEC2_ENABLE, 1);
         clks(1);
         chk({sb, sa}, {dv[k[3:2]], dv[k[1:0]]});
         chk({s1, s0}, {dv[~k[3:2]], dv[~k[1:0]]});
         apb(1, `RVS_IDX_SEC2_ENABLE, 0);
         clks(1);
         chk({sa, sb, s0, s1}, 0);
      end
      $display("scaling test done");
      apb(1, `RVS_IDX_SEC1_ENABLE, 1);
      for (k = 0; k < 5; k++) begin
         if (k == 4) apb(1, `RVS_IDX_SEC1_ENABLE, 0);
         if (k < 4) sel = $urandom;
         apb(1, `RVS_IDX_FREQ_SELECT, k < 4 ? sel : ~sel);
         apb(1, `RVS_IDX_SYS_PLL_SELECT, k[1:0]);
         apb(1, `RVS_IDX_SOFT_START, 1);
         apb(0, `RVS_IDX_SOFT_START, 0);
         chk(rd, 1);
         clks(80);
         chk(rom_translation, sel);
         if (k < 4) chk(rom_sys_pll, k);
         if (k < 4) chk({pll_n, dbl, cry}, pl[k]);
         apb(0, `RVS_IDX_SOFT_START, 0);
         chk(rd, 0);
      end
      apb(0, `RVS_IDX_SEC1_ENABLE, 0);
      chk(rd, 0);
      rst(1);
      apb(1, `RVS_IDX_SEC1_ENABLE, 1);
      apb(1, `RVS_IDX_FREQ_SELECT, 8'h5A);
      apb(1, `RVS_IDX_SEC2_ENABLE, 1);
      apb(1, `RVS_IDX_REF_SCALE, 8'h0F);
      apb(1, `RVS_IDX_SOFT_START, 1);
      clks(80);
      chk(rom_translation, 0);
      chk({sa, sb}, 0);
      $display("preset test done");
      test_done;
   end
endmodule // tb_top
